/* rtl/pg_defs.svh */
// Timing counts, mapping constants and coefficients of the power gate timer
`ifndef PG_DEFS_SVH
`define PG_DEFS_SVH

// ------------------------------------------------------------
// Clock and time base
// ------------------------------------------------------------
`define CLK_PERIOD_NS     10
`define NS_PER_MS         1000000
`define CYCLES_PER_MS     (`NS_PER_MS / `CLK_PERIOD_NS)

// ------------------------------------------------------------
// Manual trigger and drive timing, in ms
// ------------------------------------------------------------
`define DEBOUNCE_MS       20
`define MANUAL_RESP_MS    10
`define TAIL_MS           50
`define MANUAL_TOL_MS     5

// ------------------------------------------------------------
// Resistance code to interval mapping (code = ohms / 100)
// ------------------------------------------------------------
`define RD_MIN            5
`define RD_MAX            1700
`define SHORT_RD_MAX      45
`define SHORT_MS_PER_RD   20
`define MIN_LONG_MS       1000
`define VALUE_PER_MS      1000

// Interval range bounds per coefficient set, in ms
`define BOUND_0           1000
`define BOUND_1           5000
`define BOUND_2           10000
`define BOUND_3           100000
`define BOUND_4           1000000

// Quadratic coefficients scaled by 1000
`define COEF_A_0          2253
`define COEF_B_0          -207654
`define COEF_C_0          5705679
`define COEF_A_1          -1284
`define COEF_B_1          469861
`define COEF_C_1          -26518889
`define COEF_A_2          1972
`define COEF_B_2          -193450
`define COEF_C_2          6921201
`define COEF_A_3          2617
`define COEF_B_3          -562407
`define COEF_C_3          59577934
`define COEF_A_4          3177
`define COEF_B_4          -1362571
`define COEF_C_4          345224680

`endif

/* rtl/pg_pkg.sv */
// Types and coefficient tables of the power gate timer
`include "pg_defs.svh"

package pg_pkg;

    // --------------------------------------------------------
    // Control states
    // --------------------------------------------------------
    typedef enum logic [4:0] {
        ST_MEAS = 5'b00001,
        ST_ON   = 5'b00010,
        ST_TAIL = 5'b00100,
        ST_IDLE = 5'b01000,
        ST_HOLD = 5'b10000
    } state_e;

    typedef logic signed [47:0] value_t;

    localparam int SET_COUNT = 5;

    // Coefficient sets and lower range bounds
    localparam value_t COEF_A [SET_COUNT] = '{48'(`COEF_A_0), 48'(`COEF_A_1),
        48'(`COEF_A_2), 48'(`COEF_A_3), 48'(`COEF_A_4)};
    localparam value_t COEF_B [SET_COUNT] = '{48'(`COEF_B_0), 48'(`COEF_B_1),
        48'(`COEF_B_2), 48'(`COEF_B_3), 48'(`COEF_B_4)};
    localparam value_t COEF_C [SET_COUNT] = '{48'(`COEF_C_0), 48'(`COEF_C_1),
        48'(`COEF_C_2), 48'(`COEF_C_3), 48'(`COEF_C_4)};
    localparam value_t BOUND [SET_COUNT] = '{48'(`BOUND_0), 48'(`BOUND_1),
        48'(`BOUND_2), 48'(`BOUND_3), 48'(`BOUND_4)};

endpackage : pg_pkg

/* rtl/power_gate_manual_trigger.sv */
// Power gate timer: interval mapping, manual trigger and gate drive control
//
// Contract
// - Pin on measure path, then digital input
// - High pin is manual request, both edges debounced
// - Manual request valid only after 20 ms high
// - Gate drive goes active within 10 ms
// - Manual pulse is interval minus 50 ms
// - Manual request clears all interval counters
// - Counters resume once pin returns low
// - Manual pulse length may vary about 5 ms
// - Pin held high keeps switch on
// - Finish ignored while trigger pin high
// - Manual request ignored while drive active
// - Quadratic mapping, five ranged coefficient sets
// - First nine intervals 100 ms steps
// - Long intervals from 1 s to 2 h
// - First finish rising edge ends drive
// - Drive high for last 50 ms
// - Mode high periodic, low single pulse
// - One-shot: one pulse per manual request
`timescale 1ns/1ns
`default_nettype none
`include "pg_defs.svh"

module power_gate_manual_trigger #(
    parameter int RD_W          = 11,
    parameter int IW            = 23,
    parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
    input  wire logic            mclk,
    input  wire logic            rst,
    input  wire logic            mode_pin,
    input  wire logic            interval_select_trigger_pin,
    input  wire logic            meas_done,
    input  wire logic [RD_W-1:0] meas_code,
    input  wire logic            finish_pin,
    output var  logic            gate_drive_output,
    output var  logic            meas_route
);
    import pg_pkg::*;

    localparam int PRE_W = $clog2(CYCLES_PER_MS);

    logic [1:0]      sel_sync;
    logic [1:0]      mode_sync;
    logic [1:0]      done_sync;
    logic [2:0]      fin_sync;
    logic            fin_rise;
    logic [PRE_W-1:0] pre_cnt;
    logic            ms_tick;
    logic            deb_level;
    logic            deb_prev;
    logic [4:0]      deb_cnt;
    logic            manual_req;
    state_e          state;
    logic [IW-1:0]   ms_cnt;
    logic [IW-1:0]   interval_ms;
    logic [IW-1:0]   tail_at;
    logic            finish_used;
    value_t          rd_s;
    value_t          v_set [SET_COUNT];
    logic            in_rng [SET_COUNT];
    value_t          sel_v;
    logic [IW-1:0]   next_interval;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------

    // Two flops per pin, a third for the finish edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            sel_sync  <= 2'h0;
            mode_sync <= 2'h0;
            done_sync <= 2'h0;
            fin_sync  <= 3'h0;
        end else begin
            sel_sync  <= {sel_sync[0], interval_select_trigger_pin};
            mode_sync <= {mode_sync[0], mode_pin};
            done_sync <= {done_sync[0], meas_done};
            fin_sync  <= {fin_sync[1:0], finish_pin};
        end
    end

    assign fin_rise = fin_sync[1] & ~fin_sync[2];

    // ------------------------------------------------------------
    // Millisecond time base
    // ------------------------------------------------------------

    // Free running prescaler
    always_ff @(posedge mclk) begin
        if (rst) begin
            pre_cnt <= '0;
            ms_tick <= 1'b0;
        end else if (pre_cnt == PRE_W'(CYCLES_PER_MS - 1)) begin
            pre_cnt <= '0;
            ms_tick <= 1'b1;
        end else begin
            pre_cnt <= pre_cnt + PRE_W'(1);
            ms_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Manual trigger debounce
    // ------------------------------------------------------------

    // Level flips only after a full stable window on either edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            deb_level <= 1'b0;
            deb_cnt   <= 5'h0;
        end else if (meas_route) begin
            deb_cnt   <= 5'h0;
        end else if (sel_sync[1] == deb_level) begin
            deb_cnt   <= 5'h0;
        end else if (ms_tick) begin
            if (deb_cnt == 5'(`DEBOUNCE_MS)) begin
                deb_level <= ~deb_level;
                deb_cnt   <= 5'h0;
            end else begin
                deb_cnt   <= deb_cnt + 5'h1;
            end
        end
    end

    // Rising edge of the debounced level
    always_ff @(posedge mclk) begin
        if (rst) begin
            deb_prev <= 1'b0;
        end else begin
            deb_prev <= deb_level;
        end
    end

    assign manual_req = deb_level & ~deb_prev;

    // ------------------------------------------------------------
    // Resistance code to interval
    // ------------------------------------------------------------

    assign rd_s = 48'(meas_code);

    // One quadratic per coefficient set with its range check
    for (genvar k = 0; k < SET_COUNT; k++) begin : g_set
        assign v_set[k] = COEF_A[k] * rd_s * rd_s + COEF_B[k] * rd_s + COEF_C[k];
        if (k == SET_COUNT - 1) begin : g_top
            assign in_rng[k] = v_set[k] > BOUND[k] * 48'(`VALUE_PER_MS);
        end else begin : g_mid
            assign in_rng[k] = (v_set[k] > BOUND[k] * 48'(`VALUE_PER_MS)) &&
                               (v_set[k] <= BOUND[k+1] * 48'(`VALUE_PER_MS));
        end
    end

    // Short codes map linearly, others take the first set in range
    always_comb begin
        sel_v = 48'(`MIN_LONG_MS) * 48'(`VALUE_PER_MS);
        for (int k = SET_COUNT - 1; k >= 0; k--) begin
            if (in_rng[k]) begin
                sel_v = v_set[k];
            end
        end
        if (meas_code <= RD_W'(`SHORT_RD_MAX)) begin
            next_interval = IW'(meas_code) * IW'(`SHORT_MS_PER_RD);
        end else begin
            next_interval = IW'(sel_v / 48'(`VALUE_PER_MS));
        end
    end

    assign tail_at = interval_ms - IW'(`TAIL_MS + 1);

    // ------------------------------------------------------------
    // Gate drive control
    // ------------------------------------------------------------

    // Main sequence; gate drive low means switch on
    always_ff @(posedge mclk) begin
        if (rst) begin
            state             <= ST_MEAS;
            gate_drive_output <= 1'b1;
            meas_route        <= 1'b1;
            interval_ms       <= '0;
            ms_cnt            <= '0;
            finish_used       <= 1'b0;
        end else if (state != ST_MEAS && manual_req && gate_drive_output) begin
            state             <= ST_HOLD;
            gate_drive_output <= 1'b0;
            ms_cnt            <= '0;
            finish_used       <= 1'b0;
        end else begin
            case (state)
                ST_MEAS: begin
                    if (done_sync[1]) begin
                        interval_ms       <= next_interval;
                        meas_route        <= 1'b0;
                        state             <= ST_ON;
                        gate_drive_output <= 1'b0;
                        ms_cnt            <= '0;
                    end
                end
                ST_HOLD: begin
                    // Counters frozen until the pin settles low
                    ms_cnt <= '0;
                    if (!deb_level) begin
                        state <= ST_ON;
                    end
                end
                ST_ON: begin
                    if (ms_tick) begin
                        ms_cnt <= ms_cnt + IW'(1);
                    end
                    if (fin_rise && !finish_used && !deb_level && !sel_sync[1]) begin
                        gate_drive_output <= 1'b1;
                        finish_used       <= 1'b1;
                        state             <= ST_TAIL;
                    end else if (ms_tick && ms_cnt == tail_at) begin
                        gate_drive_output <= 1'b1;
                        state             <= ST_TAIL;
                    end
                end
                ST_TAIL: begin
                    if (ms_tick) begin
                        if (ms_cnt == interval_ms - IW'(1)) begin
                            ms_cnt      <= '0;
                            finish_used <= 1'b0;
                            if (mode_sync[1]) begin
                                state             <= ST_ON;
                                gate_drive_output <= 1'b0;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end else begin
                            ms_cnt <= ms_cnt + IW'(1);
                        end
                    end
                end
                ST_IDLE: begin
                    gate_drive_output <= 1'b1;
                end
                default: begin
                    state             <= ST_IDLE;
                    gate_drive_output <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Cycles the synchronised pin has stayed high
    logic [31:0] high_run;
    always_ff @(posedge mclk) begin
        if (rst || !sel_sync[1]) begin
            high_run <= 32'h0;
        end else if (high_run != 32'hffffffff) begin
            high_run <= high_run + 32'h1;
        end
    end

    a_route_meas: assert property (state == ST_MEAS |-> meas_route && gate_drive_output)
        else $error("measure path not held during reading");
    a_deb_window: assert property ($rose(deb_level) |-> high_run >= 32'(`DEBOUNCE_MS * CYCLES_PER_MS))
        else $error("manual request accepted too early");
    a_manual_on: assert property (manual_req && gate_drive_output && !meas_route
        |=> !gate_drive_output && state == ST_HOLD)
        else $error("gate drive not active after manual request");
    a_hold_clear: assert property (state == ST_HOLD |=> ms_cnt == '0 && !gate_drive_output)
        else $error("counters run while trigger held");
    a_restart_low: assert property (state == ST_HOLD && !deb_level |=> state == ST_ON)
        else $error("counters did not restart on pin low");
    a_finish_ignore: assert property (state == ST_ON && fin_rise && deb_level
        && !(ms_tick && ms_cnt == tail_at) |=> !gate_drive_output)
        else $error("finish acted while trigger high");
    a_ignore_active: assert property (manual_req && !gate_drive_output |=> state != ST_HOLD)
        else $error("manual request taken while drive active");
    a_finish_first: assert property (state == ST_ON && fin_rise && !finish_used && !deb_level
        && !sel_sync[1] |=> gate_drive_output && state == ST_TAIL)
        else $error("finish edge did not end drive");
    a_tail_start: assert property (state == ST_ON && ms_tick && ms_cnt == tail_at
        && !manual_req |=> gate_drive_output)
        else $error("drive not released before interval end");
    a_mode_end: assert property (state == ST_TAIL && ms_tick && ms_cnt == interval_ms - IW'(1)
        && !manual_req |=> (mode_sync[1] ? !gate_drive_output : state == ST_IDLE)
        && ms_cnt == '0)
        else $error("wrong action at interval end");
    a_short_map: assert property (state == ST_MEAS && done_sync[1] && meas_code <= RD_W'(`SHORT_RD_MAX)
        |=> interval_ms == IW'($past(meas_code)) * IW'(`SHORT_MS_PER_RD))
        else $error("short interval mapping wrong");

    c_manual: cover property (state == ST_HOLD ##1 state == ST_ON);
    c_finish: cover property (state == ST_ON && fin_rise && !finish_used ##1 state == ST_TAIL);
    c_period: cover property (state == ST_TAIL ##1 state == ST_ON);
    c_idle: cover property (state == ST_TAIL ##1 state == ST_IDLE);

endmodule : power_gate_manual_trigger

`default_nettype wire

/* tb/host_model.sv */
// Host and resistance reading model facing the power gate timer
`timescale 1ns/1ns
`default_nettype none

module host_model #(
    parameter int MEAS_WAIT = 40
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [10:0] code,
    input  wire logic        fin_go,
    input  wire logic [15:0] fin_delay,
    output var  logic        meas_done,
    output var  logic [10:0] meas_code,
    output var  logic        finish_pin
);
    int meas_cnt = 0;
    int fin_cnt  = 0;

    initial begin
        meas_done  = 1'b0;
        meas_code  = 11'h005;
        finish_pin = 1'b0;
    end

    // Reading time after reset and finish delay countdown
    always @(posedge mclk) begin
        if (rst) begin
            meas_cnt <= 0;
        end else if (meas_cnt < MEAS_WAIT) begin
            meas_cnt <= meas_cnt + 1;
        end
        if (fin_go) begin
            fin_cnt <= int'(fin_delay) + 4;
        end else if (fin_cnt != 0) begin
            fin_cnt <= fin_cnt - 1;
        end
    end

    // Outputs move on the falling edge, away from the sampling edge
    always @(negedge mclk) begin
        meas_done  <= !rst && meas_cnt == MEAS_WAIT;
        meas_code  <= code;
        finish_pin <= fin_cnt != 0 && fin_cnt <= 4;
    end
endmodule // host_model

`default_nettype wire

/* tb/tb.sv */
// Self-checking bench of the power gate timer
`timescale 1ns/1ns
`default_nettype none

module tb;
    localparam int CPM = 10;
    logic        mclk;
    logic        rst;
    logic        mode_pin;
    logic        pin;
    logic        fin_go;
    logic [15:0] fin_delay;
    logic [10:0] code;
    logic        meas_done;
    logic [10:0] meas_code;
    logic        finish_pin;
    logic        gate_drive_output;
    logic        meas_route;
    int          err_count;
    int          checked;
    int          seed;
    int          ims;
    int          n;
    int          h;
    int          t;

    power_gate_manual_trigger #(.CYCLES_PER_MS(CPM)) dut (
        .mclk                        (mclk),
        .rst                         (rst),
        .mode_pin                    (mode_pin),
        .interval_select_trigger_pin (pin),
        .meas_done                   (meas_done),
        .meas_code                   (meas_code),
        .finish_pin                  (finish_pin),
        .gate_drive_output           (gate_drive_output),
        .meas_route                  (meas_route)
    );

    host_model #(.MEAS_WAIT(40)) host (
        .mclk       (mclk),
        .rst        (rst),
        .code       (code),
        .fin_go     (fin_go),
        .fin_delay  (fin_delay),
        .meas_done  (meas_done),
        .meas_code  (meas_code),
        .finish_pin (finish_pin)
    );

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %0d expected %0d", $time, seen, exp);
        end
    endtask

    task automatic in_range(input int v, input int lo, input int hi);
        check(32'(v >= lo && v <= hi), 32'h1);
    endtask

    // Cycles the drive output keeps a level, capped at limit
    task automatic hold_len(input logic lvl, input int limit, output int cnt);
        cnt = 0;
        while (gate_drive_output === lvl && cnt < limit) begin
            @(negedge mclk);
            cnt++;
        end
    endtask

    task automatic wait_ms(input int ms);
        repeat (ms * CPM) @(negedge mclk);
    endtask

    task automatic send_finish(input int ms);
        fin_delay = 16'(ms * CPM);
        fin_go = 1'b1;
        @(negedge mclk);
        fin_go = 1'b0;
    endtask

    // Short codes map linearly, 20 ms per code step
    function automatic int exp_ms(input logic [10:0] c);
        return int'(c) * 20;
    endfunction

    // Codes just above one second use the first quadratic set, scaled by 1000
    function automatic int exp_long(input logic [10:0] c);
        longint ci;
        longint v;
        ci = longint'(c);
        v = pg_pkg::COEF_A[0] * ci * ci + pg_pkg::COEF_B[0] * ci + pg_pkg::COEF_C[0];
        return int'(v / 1000);
    endfunction

    task automatic give_verdict;
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog against a hung drive output
    initial begin
        #(60000 * 10);
        err_count++;
        give_verdict();
    end

    initial begin
        seed = 18;
        err_count = 0;
        checked = 0;
        rst = 1'b1;
        mode_pin = 1'b1;
        pin = 1'b0;
        fin_go = 1'b0;
        fin_delay = 16'h0000;
        code = 11'(10 + ($unsigned($random(seed)) % 6));
        ims = exp_ms(code);
        repeat (6) @(negedge mclk);
        check(gate_drive_output, 1'b1);
        check(meas_route, 1'b1);
        rst = 1'b0;
        // Reading ends: pin leaves measure path as first pulse starts
        hold_len(1'b1, 100, n);
        check(meas_route, 1'b0);
        in_range(n, 40, 52);
        // Free-running pulse, then tail, then next pulse
        hold_len(1'b0, 20000, n);
        in_range(n, (ims - 51) * CPM, (ims - 49) * CPM);
        hold_len(1'b1, 20000, n);
        in_range(n, 49 * CPM, 51 * CPM);
        // Finish cuts pulse; a second edge in the interval does nothing
        t = 20 + ($unsigned($random(seed)) % 40);
        send_finish(t);
        hold_len(1'b0, 20000, n);
        in_range(n, t * CPM + 1, t * CPM + 8);
        send_finish(10);
        hold_len(1'b1, 20000, n);
        in_range(n, (ims - t - 2) * CPM, (ims - t + 1) * CPM);
        // Press while switched on is ignored, and so is a finish during it
        pin = 1'b1;
        send_finish(25);
        wait_ms(30);
        pin = 1'b0;
        mode_pin = 1'b0;
        hold_len(1'b0, 20000, n);
        in_range(n + 30 * CPM + 1, (ims - 51) * CPM, (ims - 49) * CPM);
        hold_len(1'b1, ims * CPM, n);
        check(n, ims * CPM);
        // Short press filtered out
        pin = 1'b1;
        wait_ms(10);
        pin = 1'b0;
        hold_len(1'b1, 40 * CPM, n);
        check(n, 40 * CPM);
        // Long manual press in one-shot, then periodic mode
        for (int m = 0; m < 2; m++) begin
            mode_pin = m[0];
            h = ims + ($unsigned($random(seed)) % 30);
            pin = 1'b1;
            hold_len(1'b1, 40 * CPM, n);
            in_range(n, 20 * CPM, 31 * CPM);
            send_finish(5);
            wait_ms(h);
            check(gate_drive_output, 1'b0);
            check(gate_drive_output, 1'b0);
            pin = 1'b0;
            hold_len(1'b0, 20000, n);
            in_range(n, (ims - 35) * CPM, (ims - 24) * CPM);
            hold_len(1'b1, 60 * CPM, n);
            if (m == 0) begin
                check(n, 60 * CPM);
            end else begin
                in_range(n, 49 * CPM, 51 * CPM);
            end
        end
        // Mid-run reset, then a long code mapped by the quadratic law
        code = 11'h035;
        ims = exp_long(code);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        check(gate_drive_output, 1'b1);
        check(meas_route, 1'b1);
        rst = 1'b0;
        hold_len(1'b1, 100, n);
        in_range(n, 40, 52);
        hold_len(1'b0, 20000, n);
        in_range(n, (ims - 51) * CPM, (ims - 49) * CPM);
        give_verdict();
    end
endmodule // tb

`default_nettype wire
